// [bcc_top.sv]
// closed-loop commutation, speed command and axi4-lite registers
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bcc_top #(
  parameter int unsigned STOP_CYC = bcc_pkg::STOP_CYC,
  parameter int unsigned CNT_W    = 24
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic signed [11:0]   cur_sample,
  input  wire logic                 cur_valid,
  input  wire logic [9:0]           speed_level,
  input  wire logic                 speed_level_valid,
  input  wire logic                 speed_pin,
  output bcc_pkg::bcc_gate_t        gate_r,
  output logic [2:0]                drive_state_r,
  output logic [8:0]                speed_eff_r
);
  // register bus
  bcc_pkg::bcc_ctrl_t ctrl_r;
  logic [8:0]         serial_speed_command_r;
  logic [1:0]         bresp_r;
  logic               bvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic               rvalid_r;
  logic [31:0]        adv_word;
  logic [31:0]        status_word;

  wire        wr_go   = ce & s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  wire        rd_go   = ce & s_axi_arvalid & ~rvalid_r;
  wire [31:0] wmask   = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                         {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire        wr_ctrl = s_axi_awaddr == bcc_pkg::OFF_CTRL;
  wire        wr_spd  = s_axi_awaddr == bcc_pkg::OFF_SPEED;
  wire        wr_hit  = wr_ctrl | wr_spd;
  wire [31:0] ctrl_w  = {15'h0000, ctrl_r};
  wire [31:0] ctrl_nw = (ctrl_w & ~wmask) | (s_axi_wdata & wmask);
  wire [31:0] spd_w   = {23'h000000, serial_speed_command_r};
  wire [31:0] spd_nw  = (spd_w & ~wmask) | (s_axi_wdata & wmask);
  wire        rd_hit  = s_axi_araddr[1:0] == 2'h0;
  wire [31:0] rd_mux  =
    (s_axi_araddr == bcc_pkg::OFF_CTRL)   ? ctrl_w :
    (s_axi_araddr == bcc_pkg::OFF_SPEED)  ? spd_w :
    (s_axi_araddr == bcc_pkg::OFF_STATUS) ? status_word :
    (s_axi_araddr == bcc_pkg::OFF_ADV)    ? adv_word : 32'h00000000;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rvalid  = rvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r                 <= bcc_pkg::CTRL_RST;
      serial_speed_command_r <= 9'h000;
      bvalid_r               <= 1'b0;
      bresp_r                <= bcc_pkg::RESP_OKAY;
      rvalid_r               <= 1'b0;
      rresp_r                <= bcc_pkg::RESP_OKAY;
      rdata_r                <= 32'h00000000;
    end else if (ce) begin
      if (wr_go && wr_ctrl) ctrl_r <= bcc_pkg::bcc_ctrl_t'(ctrl_nw[16:0]);
      if (wr_go && wr_spd) serial_speed_command_r <= spd_nw[8:0];
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_hit ? bcc_pkg::RESP_OKAY : bcc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // speed pin synchroniser
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r  <= 1'b0;
    end else if (ce) begin
      pin_s1_r <= speed_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r  <= pin_s2_r;
    end
  end

  // pwm duty measurement
  logic [CNT_W-1:0] pw_per_r;
  logic [CNT_W-1:0] pw_hi_r;
  logic [CNT_W-1:0] pw_low_r;
  logic [8:0]       pw_cmd_r;
  wire              pin_rise = pin_s2_r & ~pin_d_r;
  wire              pw_stop  = pw_low_r >= CNT_W'(STOP_CYC);
  wire [CNT_W+8:0]  pw_prod  = (CNT_W+9)'(pw_hi_r) * (CNT_W+9)'(bcc_pkg::CMD_MAX);
  wire [CNT_W+8:0]  pw_quot  = (pw_per_r == '0) ? '0 :
                               pw_prod / (CNT_W+9)'(pw_per_r);
  wire [8:0]        pw_duty  = (pw_quot > (CNT_W+9)'(bcc_pkg::CMD_MAX)) ?
                               bcc_pkg::CMD_MAX : pw_quot[8:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pw_per_r <= '0;
      pw_hi_r  <= '0;
      pw_low_r <= '0;
      pw_cmd_r <= 9'h000;
    end else if (ce) begin
      pw_per_r <= pin_rise ? CNT_W'(1) : pw_per_r + CNT_W'(!(&pw_per_r));
      if (pin_rise) pw_hi_r <= CNT_W'(1);
      else if (pin_s2_r) pw_hi_r <= pw_hi_r + CNT_W'(!(&pw_hi_r));
      if (pin_s2_r) pw_low_r <= '0;
      else if (!pw_stop) pw_low_r <= pw_low_r + CNT_W'(1);
      if (pw_stop) pw_cmd_r <= 9'h000;
      else if (pin_rise) pw_cmd_r <= pw_duty;
    end
  end

  // analog level to command
  logic [8:0] ana_cmd_r;
  wire  [9:0] ana_ofs  = speed_level - bcc_pkg::ANA_ZS;
  wire  [18:0] ana_prd = 19'(ana_ofs) * 19'(bcc_pkg::CMD_MAX);
  wire  [18:0] ana_q   = ana_prd / 19'(bcc_pkg::ANA_FS - bcc_pkg::ANA_ZS);
  wire  [8:0] ana_lin  = ana_q[8:0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ana_cmd_r <= 9'h000;
    end else if (ce && speed_level_valid) begin
      if (speed_level > bcc_pkg::ANA_FS) ana_cmd_r <= bcc_pkg::CMD_MAX;
      else if (speed_level < bcc_pkg::ANA_ZS) ana_cmd_r <= 9'h000;
      else ana_cmd_r <= ana_lin;
    end
  end

  // command source and slew limiter
  logic [CNT_W-1:0] slew_ctr_r;
  wire  [8:0] pin_cmd    = ctrl_r.speed_source_pwm_sel ? pw_cmd_r : ana_cmd_r;
  wire  [8:0] target     = ctrl_r.serial_speed_a ?
                           serial_speed_command_r : pin_cmd;
  wire  [CNT_W-1:0] slew_per = CNT_W'(bcc_pkg::SLEW_BASE_CYC) <<
                               ctrl_r.loop_slew_limit_sel;
  wire  slew_tick = slew_ctr_r >= slew_per - CNT_W'(1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slew_ctr_r  <= '0;
      speed_eff_r <= 9'h000;
    end else if (ce) begin
      slew_ctr_r <= slew_tick ? '0 : slew_ctr_r + CNT_W'(1);
      if (slew_tick && speed_eff_r < target)
        speed_eff_r <= speed_eff_r + 9'h001;
      else if (slew_tick && speed_eff_r > target)
        speed_eff_r <= speed_eff_r - 9'h001;
    end
  end

  // feedback filter and back-emf estimate
  logic signed [12:0] fb_r;
  logic signed [12:0] bemf_r;
  logic               bemf_neg_r;
  logic [11:0]        bemf_pk_r;
  logic [11:0]        bemf_amp_r;
  wire  u_hi = (drive_state_r == 3'h0) | (drive_state_r == 3'h1);
  wire  u_lo = (drive_state_r == 3'h3) | (drive_state_r == 3'h4);
  wire  signed [12:0] volt_u = u_hi ? $signed({4'h0, speed_eff_r}) :
                               u_lo ? -$signed({4'h0, speed_eff_r}) : 13'sh0000;
  wire  signed [12:0] fb_err = $signed({cur_sample[11], cur_sample}) - fb_r;
  wire  signed [12:0] bemf_n = volt_u - fb_r;
  wire  [12:0]        bemf_a = bemf_n[12] ? 13'(-bemf_n) : 13'(bemf_n);
  wire  zc_rise = cur_valid & bemf_neg_r & ~bemf_n[12];
  wire  zc_fall = cur_valid & ~bemf_neg_r & bemf_n[12];
  wire  upd     = zc_rise | (ctrl_r.half_cycle_update_sel & zc_fall);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_r       <= 13'sh0000;
      bemf_r     <= 13'sh0000;
      bemf_neg_r <= 1'b0;
      bemf_pk_r  <= 12'h000;
      bemf_amp_r <= 12'h000;
    end else if (ce && cur_valid) begin
      fb_r       <= fb_r + (fb_err >>> ctrl_r.feedback_attenuation_sel);
      bemf_r     <= bemf_n;
      bemf_neg_r <= bemf_n[12];
      if (zc_rise) begin
        bemf_amp_r <= bemf_pk_r;
        bemf_pk_r  <= 12'h000;
      end else if (bemf_a[11:0] > bemf_pk_r) begin
        bemf_pk_r <= bemf_a[11:0];
      end
    end
  end

  // advance time
  wire [16:0] tset = 17'(17'(ctrl_r.advance_time_mantissa) *
                     17'(bcc_pkg::TSET_CYC)) <<
                     ctrl_r.advance_time_exponent;
  wire [11:0] amp_u   = {3'h0, speed_eff_r};
  wire [11:0] u_minus = (bemf_amp_r >= amp_u) ? 12'h000 : amp_u - bemf_amp_r;
  wire [28:0] sc_prod = 29'(tset) * 29'(u_minus);
  wire [28:0] sc_quot = (amp_u == 12'h000) ? 29'h0 : sc_prod / 29'(amp_u);
  wire [16:0] adv     = ctrl_r.advance_scaling_sel ?
                        sc_quot[16:0] : tset;
  assign adv_word    = {15'h0000, adv};
  assign status_word = {19'h00000, (speed_eff_r == 9'h000),
                        drive_state_r, speed_eff_r};

  // commutation timing
  logic [CNT_W-1:0] elapsed_r;
  logic [CNT_W-1:0] period_r;
  logic [CNT_W-1:0] sector_r;
  wire  [CNT_W-1:0] sec_len = ctrl_r.half_cycle_update_sel ?
                              period_r / CNT_W'(3) : period_r / CNT_W'(6);
  wire  [CNT_W-1:0] step_at = (sec_len > CNT_W'(adv)) ?
                              sec_len - CNT_W'(adv) : CNT_W'(1);
  wire  [2:0] st_inc  = (drive_state_r == 3'h5) ? 3'h0 : drive_state_r + 3'h1;
  wire  [2:0] st_sync = zc_fall ? 3'h3 : 3'h0;
  wire  step = (period_r != '0) & (sector_r >= step_at);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_r     <= '0;
      period_r      <= '0;
      sector_r      <= '0;
      drive_state_r <= bcc_pkg::STATE_RST;
    end else if (ce) begin
      if (upd) begin
        period_r      <= elapsed_r;
        elapsed_r     <= '0;
        sector_r      <= '0;
        drive_state_r <= st_sync;
      end else begin
        elapsed_r <= elapsed_r + CNT_W'(!(&elapsed_r));
        if (step) begin
          sector_r      <= '0;
          drive_state_r <= st_inc;
        end else begin
          sector_r <= sector_r + CNT_W'(!(&sector_r));
        end
      end
    end
  end

  // output pwm carrier and gates
  logic [11:0] carr_r;
  wire  [11:0] carr_per = ctrl_r.output_pwm_rate_sel ?
                          12'(bcc_pkg::PWM_HI_CYC) : 12'(bcc_pkg::PWM_LO_CYC);
  wire  [20:0] duty_p   = 21'(carr_per) * 21'(speed_eff_r);
  wire  [11:0] duty_c   = duty_p[20:9];
  wire         on       = (carr_r < duty_c) & (speed_eff_r != 9'h000);
  logic [2:0]  hi_sel;
  logic [2:0]  lo_sel;
  always_comb begin
    case (drive_state_r)
      3'h0: begin hi_sel = 3'b001; lo_sel = 3'b100; end
      3'h1: begin hi_sel = 3'b001; lo_sel = 3'b010; end
      3'h2: begin hi_sel = 3'b100; lo_sel = 3'b010; end
      3'h3: begin hi_sel = 3'b100; lo_sel = 3'b001; end
      3'h4: begin hi_sel = 3'b010; lo_sel = 3'b001; end
      3'h5: begin hi_sel = 3'b010; lo_sel = 3'b100; end
      default: begin hi_sel = 3'b000; lo_sel = 3'b000; end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      carr_r <= 12'h000;
      gate_r <= '0;
    end else if (ce) begin
      carr_r   <= (carr_r >= carr_per - 12'h001) ? 12'h000 :
                  carr_r + 12'h001;
      gate_r.u <= on ? hi_sel : 3'b000;
      gate_r.l <= (speed_eff_r != 9'h000) ? lo_sel : 3'b000;
    end
  end
endmodule : bcc_top
`default_nettype wire

// [bcc_pkg.sv]
// constants and types for the closed-loop commutation controller
// Contract
// - closed loop samples U current, estimates back-EMF, picks drive state from it
// - half-cycle mode updates drive state at rising and falling zero crossings
// - full-cycle mode updates drive state only at rising zero crossings
// - analog speed: above full scale max, linear between, below zero scale stop
// - pwm speed: command proportional to measured input duty cycle 0..100 percent; at 100 percent (no rising edge) the command holds its last value
// - pwm speed: pin low for stop interval commands stop
// - output pwm is 25 kHz when rate bit is 0, 50 kHz when 1
// - serial serial_speed_a takes serial command and ignores the speed pin
// - serial command is 9 bits, 0x1FF is maximum
// - effective speed command change rate limited by 3-bit slew field
// - current feedback attenuated by 2-bit coefficient field
// - scaling bit 0: advance time equals setting time
// - scaling bit 1: advance equals setting times (U minus bemf) over U
// - setting time is 2.5 us times mantissa shifted left by exponent
`default_nettype none
package bcc_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned TSET_UNIT_PS  = 2_500_000;
  localparam int unsigned TSET_CYC      =
    TSET_UNIT_PS / (1_000_000 / (CLK_HZ / 1_000_000));
  localparam int unsigned PWM_LO_HZ     = 25_000;
  localparam int unsigned PWM_HI_HZ     = 50_000;
  localparam int unsigned PWM_LO_CYC    = CLK_HZ / PWM_LO_HZ;
  localparam int unsigned PWM_HI_CYC    = CLK_HZ / PWM_HI_HZ;
  localparam int unsigned STOP_MS       = 200;
  localparam int unsigned STOP_CYC      = STOP_MS * (CLK_HZ / 1000);
  localparam int unsigned SLEW_BASE_CYC = 64;
  localparam logic [8:0]  CMD_MAX       = 9'h1FF;
  localparam logic [9:0]  ANA_ZS        = 10'h040;
  localparam logic [9:0]  ANA_FS        = 10'h3C0;
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_SPEED     = 4'h4;
  localparam logic [3:0]  OFF_STATUS    = 4'h8;
  localparam logic [3:0]  OFF_ADV       = 4'hC;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [2:0]  STATE_RST     = 3'h0;

  typedef struct packed {
    logic [2:0] advance_time_exponent;
    logic [3:0] advance_time_mantissa;
    logic [1:0] feedback_attenuation_sel;
    logic [2:0] loop_slew_limit_sel;
    logic       advance_scaling_sel;
    logic       serial_speed_a;
    logic       output_pwm_rate_sel;
    logic       speed_source_pwm_sel;
    logic       half_cycle_update_sel;
  } bcc_ctrl_t;

  localparam bcc_ctrl_t CTRL_RST = '0;

  typedef struct packed {
    logic [2:0] u;
    logic [2:0] l;
  } bcc_gate_t;
endpackage : bcc_pkg
`default_nettype wire

// [bcc_props.sv]
// port assertions for the commutation controller
`timescale 1ns/1ns
`default_nettype none
module bcc_props #(
  parameter int unsigned STOP_CYC = bcc_pkg::STOP_CYC,
  parameter int unsigned CNT_W    = 24
) (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire bcc_pkg::bcc_gate_t gate_r,
  input wire logic [2:0]         drive_state_r,
  input wire logic [8:0]         speed_eff_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  slew_step_a: assert property (
    $changed(speed_eff_r) |-> speed_eff_r == $past(speed_eff_r) + 9'h1
    || speed_eff_r == $past(speed_eff_r) - 9'h1) else $error("speed jump");
  slew_hold_a: assert property (
    $changed(speed_eff_r) |=> $stable(speed_eff_r) [*8])
    else $error("speed steps too fast");
  state_range_a: assert property (
    drive_state_r <= 3'h5) else $error("drive state out of range");
  state_step_a: assert property (
    $changed(drive_state_r) |-> drive_state_r == 3'h0 || drive_state_r == 3'h3
    || drive_state_r == $past(drive_state_r) + 3'h1)
    else $error("drive state skipped");
  gate_excl_a: assert property (
    (gate_r.u & gate_r.l) == 3'h0) else $error("phase shoot through");
  stop_off_a: assert property (
    speed_eff_r == 9'h0 && $past(speed_eff_r) == 9'h0 |-> gate_r == '0)
    else $error("gates on while stopped");
  low_side_a: assert property (
    drive_state_r == 3'h0 && $past(drive_state_r) == 3'h0
    && speed_eff_r != 9'h0 && $past(speed_eff_r) != 9'h0
    |-> gate_r.l == 3'h4) else $error("wrong low side");
endmodule : bcc_props

bind bcc_top bcc_props #(.STOP_CYC(STOP_CYC), .CNT_W(CNT_W)) u_bcc_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .gate_r(gate_r),
  .drive_state_r(drive_state_r), .speed_eff_r(speed_eff_r));
`default_nettype wire

// [bcc_motor_model.sv]
// motor current and speed pin source
`timescale 1ns/1ns
`default_nettype none
module bcc_motor_model #(
  parameter int PER     = 1000,
  parameter int PIN_PER = 100
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [6:0]   duty_pct,
  output logic signed [11:0] cur_sample,
  output logic              cur_valid,
  output logic              speed_pin
);
  int ph;
  int pp;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph <= 0;
      pp <= 0;
      cur_valid <= 1'b0;
      cur_sample <= '0;
      speed_pin <= 1'b0;
    end else begin
      ph <= (ph == PER - 1) ? 0 : ph + 1;
      pp <= (pp == PIN_PER - 1) ? 0 : pp + 1;
      cur_valid <= (ph % 4 == 0);
      cur_sample <= 12'(ph < PER / 2 ? 4 * ph - 1000 : 3000 - 4 * ph);
      speed_pin <= (pp < int'(duty_pct));
    end
  end
endmodule : bcc_motor_model
`default_nettype wire

// [tb_bldc_closed_loop_commutation_ctrl.sv]
// self-checking bench for the commutation controller
`timescale 1ns/1ns
`default_nettype none
module tb_bldc_closed_loop_commutation_ctrl;
  typedef struct packed {
    logic [3:0]  wa;
    logic [31:0] wd;
    logic [3:0]  ra;
    logic [31:0] rd;
  } bcc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, lvl_v = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready;
  logic rvalid, cur_valid, speed_pin;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [9:0] lvl = '0;
  logic ce_in = 1'b1;
  logic [3:0] strb = 4'hF;
  logic [6:0] duty = '0;
  logic signed [11:0] cur_sample;
  logic [2:0] state;
  logic [8:0] eff;
  bcc_pkg::bcc_gate_t gate;
  int miscompares = 0, checks_done = 0, cyc = 0, n1, n2, n3;
  bcc_row_t rows [7] = '{
    '{4'h0, 32'hFFFFFFFF, 4'h0, 32'h0001FFFF},
    '{4'h0, 32'h0001FC00, 4'hC, 32'h00017700},
    '{4'h0, 32'h00000400, 4'hC, 32'h00000032},
    '{4'h0, 32'h00006400, 4'hC, 32'h00000384},
    '{4'h0, 32'h0001FC10, 4'hC, 32'h00000000},
    '{4'h0, 32'h00000000, 4'hC, 32'h00000000},
    '{4'h4, 32'h0000FFFF, 4'h4, 32'h000001FF}};
  always #25 aclk = ~aclk;
  bcc_top #(.STOP_CYC(200), .CNT_W(24)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cur_sample(cur_sample), .cur_valid(cur_valid), .speed_level(lvl),
    .speed_level_valid(lvl_v), .speed_pin(speed_pin), .gate_r(gate),
    .drive_state_r(state), .speed_eff_r(eff));
  bcc_motor_model #(.PER(1000), .PIN_PER(100)) u_motor (.aclk(aclk),
    .aresetn(aresetn), .duty_pct(duty), .cur_sample(cur_sample),
    .cur_valid(cur_valid), .speed_pin(speed_pin));
  task automatic wrap_up();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(negedge aclk); while (!(awready && wready));
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic lvl_set(input logic [9:0] v);
    lvl <= v;
    lvl_v <= 1'b1;
    @(posedge aclk);
    lvl_v <= 1'b0;
  endtask : lvl_set
  task automatic ramp(input int sel, input int n);
    int c;
    int lo;
    int hi;
    logic [8:0] s;
    c = 0;
    @(negedge aclk);
    s = eff;
    while (eff < s + 9'(n) && c < 20000) begin
      @(negedge aclk);
      c++;
    end
    lo = (n - 1) * (int'(bcc_pkg::SLEW_BASE_CYC) << sel);
    hi = (n + 1) * (int'(bcc_pkg::SLEW_BASE_CYC) << sel);
    chk("slew", 32'h1, 32'(c inside {[lo:hi]}));
    @(posedge aclk);
  endtask : ramp
  task automatic meas();
    logic pu;
    logic [2:0] ps;
    n1 = 0;
    n2 = 0;
    n3 = 0;
    pu = |gate.u;
    ps = state;
    repeat (8000) begin
      @(negedge aclk);
      if (|gate.u && !pu) n1++;
      if (state != ps && state == 3'h0) n2++;
      if (state != ps && state == 3'h3) n3++;
      pu = |gate.u;
      ps = state;
    end
    @(posedge aclk);
  endtask : meas
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      chk("wresp", 32'h0, 32'(r));
      rd(rows[i].ra);
      chk("rdata", rows[i].rd, d);
    end
    wr(4'h2, 32'h1);
    chk("bad_wresp", 32'h2, 32'(r));
    rd(4'h2);
    chk("bad_rresp", 32'h2, 32'(r));
    chk("bad_rdata", 32'h0, d);
    strb <= 4'h1;
    wr(4'h4, 32'h00000000);
    strb <= 4'hF;
    rd(4'h4);
    chk("strobe", 32'h100, d);
    wr(4'h4, 32'h000001FF);
    wr(4'h0, 32'h0000000A);
    ramp(0, 8);
    wr(4'h0, 32'h0000002A);
    ramp(1, 4);
    wr(4'h0, 32'h0);
    lvl_set(10'h047);
    repeat (1500) @(posedge aclk);
    rd(4'h8);
    chk("ana_mid", 32'h3, d & 32'h1FF);
    lvl_set(10'h020);
    repeat (400) @(posedge aclk);
    rd(4'h8);
    chk("ana_stop", 32'h1000, d & 32'h11FF);
    lvl_set(10'h3FF);
    ce_in <= 1'b0;
    @(negedge aclk);
    d = 32'(eff);
    repeat (200) @(negedge aclk);
    chk("ce_hold", d, 32'(eff));
    @(posedge aclk);
    ce_in <= 1'b1;
    repeat (300) @(posedge aclk);
    rd(4'h8);
    chk("ana_max", 32'h1, 32'((d & 32'h1FF) inside {[3:5]}));
    duty <= 7'h05;
    wr(4'h0, 32'h2);
    repeat (2500) @(posedge aclk);
    rd(4'h8);
    chk("pwm_duty", 32'h19, d & 32'h1FF);
    meas();
    chk("rate_lo", 32'h1, 32'(n1 inside {[10:14]}));
    chk("full_upd", 32'h1, 32'(n2 inside {[6:10]}));
    wr(4'h0, 32'h7);
    meas();
    chk("rate_hi", 32'h1, 32'(n1 inside {[20:25]}));
    chk("half_upd", 32'h1, 32'(n3 inside {[6:10]}));
    duty <= 7'h00;
    repeat (2500) @(posedge aclk);
    rd(4'h8);
    chk("pwm_stop", 32'h1000, d & 32'h11FF);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(4'h0);
    chk("ctrl_rst", 32'h0, d);
    rd(4'h4);
    chk("speed_rst", 32'h0, d);
    @(negedge aclk);
    chk("eff_rst", 32'h0, 32'(eff));
    chk("state_rst", 32'h0, 32'(state));
    chk("gate_rst", 32'h0, 32'(gate));
    @(posedge aclk);
    wrap_up();
  end
endmodule : tb_bldc_closed_loop_commutation_ctrl
`default_nettype wire
